/* src/sfc_arith_flags.sv */
/*
 * Result-derived arithmetic flags: carry, parity, nibble carry, zero, sign,
 * overflow. Purely combinational.
 * Assumes: operands already truncated by the caller's size; result is masked to size here.
 */
`timescale 1ns/10ps
module sfc_arith_flags #(
  parameter int unsigned W = 32
) (
  // Operation
  input wire logic [W-1:0] opa,
  input wire logic [W-1:0] opb,
  input wire sfc_pkg::sfc_size_e size,
  input wire sfc_pkg::sfc_alu_e op,
  // Result and flags out
  output logic [W-1:0] result,
  output logic carry_flag,
  output logic parity_flag,
  output logic nibble_carry_flag,
  output logic zero_flag,
  output logic sign_flag,
  output logic overflow_flag
);

  logic [W:0] sum;
  logic [W-1:0] bmod;
  logic [W-1:0] carries;
  logic [W-1:0] szmask;
  int unsigned top;

  // Adder with per-bit carry vector, sign bit from size
  always_comb begin
    bmod = (op == sfc_pkg::OP_SUB) ? ~opb : opb;
    sum = {1'b0, opa} + {1'b0, bmod} + {{W{1'b0}}, (op == sfc_pkg::OP_SUB)};
    case (size)
      sfc_pkg::SZ_BYTE: top = 7;
      sfc_pkg::SZ_WORD: top = 15;
      default: top = W - 1;
    endcase
    szmask = (op == sfc_pkg::OP_LOGIC) ? (opa & opb) : sum[W-1:0];
    result = szmask;
    if (top < W - 1) begin
      result = szmask & ((({{(W-1){1'b0}}, 1'b1}) << (top + 1)) - 1'b1);
    end
    carries = opa ^ bmod ^ sum[W-1:0];
    // Carry out of top bit: carry into top+1 inverted for borrow
    if (op == sfc_pkg::OP_LOGIC) begin
      carry_flag = 1'b0;
      overflow_flag = 1'b0;
      nibble_carry_flag = 1'b0;
    end else begin
      carry_flag = ((top == W - 1) ? sum[W] : (opa[top] ^ bmod[top] ^ carries[top] ? 1'b0 : 1'b0)
                    | ((top < W - 1) ? (sum[top+1] ^ opa[top+1] ^ bmod[top+1]) : 1'b0))
                   ^ (op == sfc_pkg::OP_SUB);
      overflow_flag = carries[top] ^ ((top == W - 1) ? sum[W] :
                      (sum[top+1] ^ opa[top+1] ^ bmod[top+1]));
      // Borrow out of bit 3 is the inverted carry out of it on subtraction
      nibble_carry_flag = carries[sfc_pkg::NIBBLE_BIT+1] ^ (op == sfc_pkg::OP_SUB);
    end
    parity_flag = ~^result[sfc_pkg::PARITY_BITS-1:0];
    zero_flag = (result == '0);
    sign_flag = result[top];
  end

endmodule

/* src/sfc_core.sv */
/*
 * Flags register and control word zero of the processor core, with the
 * arithmetic flag update, privilege checks, trap and interrupt gating.
 * Assumes: instruction sequencer drives one request per cycle, synchronous.
 */
`timescale 1ns/10ps
module sfc_core #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Arithmetic operation
  input wire logic alu_valid,
  input wire sfc_pkg::sfc_alu_e alu_op,
  input wire sfc_pkg::sfc_size_e alu_size,
  input wire logic [W-1:0] alu_a,
  input wire logic [W-1:0] alu_b,
  // Flags image writes
  input wire sfc_pkg::sfc_fwr_e flags_wr,
  input wire logic [31:0] flags_image,
  input wire logic [1:0] current_priv_level,
  // Control word writes
  input wire sfc_pkg::sfc_cwr_e cw_wr,
  input wire logic [31:0] cw_image,
  // Instruction events
  input wire logic instr_done,
  input wire logic bp_match,
  input wire logic io_instr,
  input wire logic string_step,
  input wire logic [2:0] string_bytes,
  input wire logic maskable_irq_pin,
  // Register views
  output logic [31:0] flags_out,
  output logic [31:0] cw_out,
  output logic [W-1:0] alu_result,
  // Exceptions and control
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic [15:0] exc_err_code,
  output logic io_direct_ok,
  output logic irq_take,
  output logic [W-1:0] index_delta,
  output logic align_check_on,
  output logic sup_write_protect
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] cw;
    logic [W-1:0] result;
    logic exc_valid;
    logic [7:0] exc_vector;
    logic [15:0] exc_err;
    logic io_ok;
    logic irq_take;
    logic [W-1:0] delta;
    logic step_armed;
  } sfc_state_s;

  sfc_state_s st_r;
  sfc_state_s st_nxt;
  logic [1:0] rst_sync_r;
  logic rst_int_b;

  logic [W-1:0] res;
  logic cf, pf, af, zf, sf, ovf;
  logic cw_bad;
  logic [31:0] cw_cand;
  logic [31:0] fl_cand;
  logic [31:0] fl_keep;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_int_b = rst_sync_r[1];

  // ****************************************
  // Leaf blocks
  // ****************************************
  sfc_arith_flags #(.W(W)) u_arith (
    .opa(alu_a),
    .opb(alu_b),
    .size(alu_size),
    .op(alu_op),
    .result(res),
    .carry_flag(cf),
    .parity_flag(pf),
    .nibble_carry_flag(af),
    .zero_flag(zf),
    .sign_flag(sf),
    .overflow_flag(ovf)
  );

  // Candidate control word: status-word load only touches low half
  always_comb begin
    if (cw_wr == sfc_pkg::CW_LMSW) begin
      cw_cand = (st_r.cw & ~sfc_pkg::CW_LOW_HALF)
                | (cw_image & sfc_pkg::CW_LOW_HALF & sfc_pkg::CW_MASK);
    end else begin
      cw_cand = cw_image & sfc_pkg::CW_MASK;
    end
  end

  sfc_cw_check u_cwchk (
    .image(cw_cand),
    .bad(cw_bad)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.exc_valid = 1'b0;
    st_nxt.exc_vector = 8'h00;
    st_nxt.exc_err = sfc_pkg::GP_ERR_ZERO;
    fl_keep = 32'h0000_0000;
    fl_cand = flags_image & sfc_pkg::FL_MASK;

    // Arithmetic flag update
    if (alu_valid) begin
      st_nxt.result = res;
      st_nxt.flags[sfc_pkg::FL_CARRY] = cf;
      st_nxt.flags[sfc_pkg::FL_PARITY] = pf;
      st_nxt.flags[sfc_pkg::FL_NIBBLE] = af;
      st_nxt.flags[sfc_pkg::FL_ZERO] = zf;
      st_nxt.flags[sfc_pkg::FL_SIGN] = sf;
      st_nxt.flags[sfc_pkg::FL_OVF] = ovf;
    end

    // Flags image loads, privilege filtering on pop and interrupt return only
    case (flags_wr)
      sfc_pkg::FW_POP_FLAGS_INSTR, sfc_pkg::FW_INTERRUPT_RETURN_INSTR: begin
        if (current_priv_level != sfc_pkg::PRIV_KERNEL) begin
          fl_keep[sfc_pkg::FL_IO_PRIV_THRESHOLD_HI] = 1'b1;
          fl_keep[sfc_pkg::FL_IO_PRIV_THRESHOLD_LO] = 1'b1;
        end
        if (current_priv_level > st_r.flags[sfc_pkg::FL_IO_PRIV_THRESHOLD_HI:sfc_pkg::FL_IO_PRIV_THRESHOLD_LO]) begin
          fl_keep[sfc_pkg::FL_IEN] = 1'b1;
        end
        st_nxt.flags = (st_r.flags & fl_keep) | (fl_cand & ~fl_keep);
      end
      sfc_pkg::FW_TASK, sfc_pkg::FW_DIRECT: begin
        st_nxt.flags = fl_cand;
      end
      default: begin
      end
    endcase

    // Control word loads with validity fault
    if (cw_wr != sfc_pkg::CW_NONE) begin
      if (cw_bad) begin
        st_nxt.exc_valid = 1'b1;
        st_nxt.exc_vector = sfc_pkg::EXC_GP;
        st_nxt.exc_err = sfc_pkg::GP_ERR_ZERO;
      end else begin
        st_nxt.cw = cw_cand;
      end
    end

    // Debug trap on completion: step flag or breakpoint
    if (instr_done) begin
      st_nxt.step_armed = st_r.flags[sfc_pkg::FL_STEP];
      if (st_r.step_armed || (!st_r.flags[sfc_pkg::FL_STEP] && bp_match)) begin
        st_nxt.exc_valid = 1'b1;
        st_nxt.exc_vector = sfc_pkg::EXC_DEBUG;
      end
    end

    // I/O permission check in protected mode
    st_nxt.io_ok = 1'b1;
    if (st_r.cw[sfc_pkg::CW_PE] && io_instr) begin
      st_nxt.io_ok = current_priv_level
                     <= st_r.flags[sfc_pkg::FL_IO_PRIV_THRESHOLD_HI:sfc_pkg::FL_IO_PRIV_THRESHOLD_LO];
    end

    // Interrupt gating
    st_nxt.irq_take = maskable_irq_pin & st_r.flags[sfc_pkg::FL_IEN];

    // String index step, sign from direction
    st_nxt.delta = '0;
    if (string_step) begin
      st_nxt.delta = st_r.flags[sfc_pkg::FL_DIR]
                     ? (W'(0) - W'(string_bytes)) : W'(string_bytes);
    end
  end

  // Register the state
  always_ff @(posedge core_clk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      st_r <= '0;
      st_r.flags <= sfc_pkg::FL_RESET;
      st_r.cw <= sfc_pkg::CW_RESET;
      st_r.io_ok <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign flags_out = st_r.flags;
  assign cw_out = st_r.cw;
  assign alu_result = st_r.result;
  assign exc_valid = st_r.exc_valid;
  assign exc_vector = st_r.exc_vector;
  assign exc_err_code = st_r.exc_err;
  assign io_direct_ok = st_r.io_ok;
  assign irq_take = st_r.irq_take;
  assign index_delta = st_r.delta;
  assign align_check_on = st_r.cw[sfc_pkg::CW_AM];
  assign sup_write_protect = st_r.cw[sfc_pkg::CW_WP];

endmodule

/* src/sfc_cw_check.sv */
/*
 * Validity check of a new control word zero image; sfc_core raises the fault.
 * Assumes: called with the full image that would be loaded.
 */
`timescale 1ns/10ps
module sfc_cw_check (
  // Candidate image
  input wire logic [31:0] image,
  // Verdict
  output logic bad
);

  // Paging without protection, or write-through off with fills on
  always_comb begin
    bad = (image[sfc_pkg::CW_PG] & ~image[sfc_pkg::CW_PE])
          | (~image[sfc_pkg::CW_CD] & image[sfc_pkg::CW_NW]);
  end

endmodule

/* src/sfc_pkg.sv */
/*
 * Package for the status-flags and control-word block: bit positions of the
 * flags register and of control word zero, reset values, operation codes.
 * Assumes: used with package-qualified names only, nothing imported.
 */
package sfc_pkg;

  // ****************************************
  // Flags register bit positions
  // ****************************************
  localparam int unsigned FL_CARRY = 0;
  localparam int unsigned FL_PARITY = 2;
  localparam int unsigned FL_NIBBLE = 4;
  localparam int unsigned FL_ZERO = 6;
  localparam int unsigned FL_SIGN = 7;
  localparam int unsigned FL_STEP = 8;
  localparam int unsigned FL_IEN = 9;
  localparam int unsigned FL_DIR = 10;
  localparam int unsigned FL_OVF = 11;
  localparam int unsigned FL_IO_PRIV_THRESHOLD_LO = 12;
  localparam int unsigned FL_IO_PRIV_THRESHOLD_HI = 13;
  localparam int unsigned NIBBLE_BIT = 3;
  localparam int unsigned PARITY_BITS = 8;

  // Writable bits of the flags register (bits 13..0, reserved 5, 3, 1 zero)
  localparam logic [31:0] FL_MASK = 32'h0000_3fd5;
  localparam logic [31:0] FL_RESET = 32'h0000_0000;

  // ****************************************
  // Control word zero bit positions
  // ****************************************
  localparam int unsigned CW_PE = 0;
  localparam int unsigned CW_MP = 1;
  localparam int unsigned CW_EM = 2;
  localparam int unsigned CW_TS = 3;
  localparam int unsigned CW_NE = 5;
  localparam int unsigned CW_WP = 16;
  localparam int unsigned CW_AM = 18;
  localparam int unsigned CW_NW = 29;
  localparam int unsigned CW_CD = 30;
  localparam int unsigned CW_PG = 31;
  localparam logic [31:0] CW_MASK = 32'he005_002f;
  localparam logic [31:0] CW_RESET = 32'h4000_0000;
  localparam logic [31:0] CW_LOW_HALF = 32'h0000_ffff;

  // ****************************************
  // Exception vectors and privilege
  // ****************************************
  localparam logic [7:0] EXC_DEBUG = 8'h01;
  localparam logic [7:0] EXC_GP = 8'h0d;
  localparam logic [15:0] GP_ERR_ZERO = 16'h0000;
  localparam logic [1:0] PRIV_KERNEL = 2'h0;

  // ****************************************
  // Operation sizes and codes
  // ****************************************
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} sfc_size_e;
  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_LOGIC} sfc_alu_e;
  typedef enum logic [2:0] {
    FW_NONE, FW_POP_FLAGS_INSTR, FW_INTERRUPT_RETURN_INSTR, FW_TASK, FW_DIRECT
  } sfc_fwr_e;
  typedef enum logic [1:0] {CW_NONE, CW_MOV, CW_LMSW} sfc_cwr_e;

endpackage

/* verif/sfc_core_asserts.sv */
/*
 * Checker for sfc_core: control word faults, privilege gates, traps.
 * Assumes: bound to sfc_core; requests wait out the reset sync window.
 */
`timescale 1ns/10ps
module sfc_core_asserts #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Requests
  input wire sfc_pkg::sfc_fwr_e flags_wr,
  input wire logic [1:0] current_priv_level,
  input wire sfc_pkg::sfc_cwr_e cw_wr,
  input wire logic [31:0] cw_image,
  input wire logic instr_done,
  input wire logic io_instr,
  input wire logic string_step,
  input wire logic [2:0] string_bytes,
  // Outputs
  input wire logic [31:0] flags_out,
  input wire logic [31:0] cw_out,
  input wire logic exc_valid,
  input wire logic [7:0] exc_vector,
  input wire logic [15:0] exc_err_code,
  input wire logic io_direct_ok,
  input wire logic irq_take,
  input wire logic [W-1:0] index_delta,
  input wire logic align_check_on,
  input wire logic sup_write_protect
);
  logic [1:0] sync_r;
  logic live;
  logic pop;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // Own copy of the reset sync, gates requests
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_r <= 2'h0;
    end else begin
      sync_r <= {sync_r[0], 1'b1};
    end
  end
  assign live = sync_r[1];
  assign pop = flags_wr == sfc_pkg::FW_POP_FLAGS_INSTR || flags_wr == sfc_pkg::FW_INTERRUPT_RETURN_INSTR;

  // ****************************************
  // Properties
  // ****************************************
  gp_paging_a: assert property (live && cw_wr == sfc_pkg::CW_MOV && cw_image[31] && !cw_image[0]
    && !instr_done |=> exc_valid && exc_vector == sfc_pkg::EXC_GP && exc_err_code == 16'h0 && $stable(cw_out))
    else $error("Paging without protection not refused");
  gp_cache_a: assert property (live && cw_wr == sfc_pkg::CW_MOV && !cw_image[30] && cw_image[29]
    && !instr_done |=> exc_valid && exc_vector == sfc_pkg::EXC_GP && $stable(cw_out))
    else $error("Bad cache pairing not refused");
  lmsw_keep_a: assert property (live && cw_wr == sfc_pkg::CW_LMSW |=> $stable(cw_out[31:16]))
    else $error("Low half load changed upper bits");
  pop_io_priv_threshold_a: assert property (live && pop && current_priv_level != 2'h0
    |=> $stable(flags_out[13:12])) else $error("Threshold changed above level zero");
  pop_ien_a: assert property (live && pop && current_priv_level > flags_out[13:12]
    |=> $stable(flags_out[9])) else $error("Enable changed above threshold");
  irq_gate_a: assert property (irq_take |-> $past(flags_out[9]))
    else $error("Interrupt taken while disabled");
  io_check_a: assert property (live && io_instr && cw_out[0] |=>
    io_direct_ok == ($past(current_priv_level) <= $past(flags_out[13:12]))) else $error("I/O check wrong");
  str_step_a: assert property (live && string_step |=> index_delta ==
    ($past(flags_out[10]) ? -W'($past(string_bytes)) : W'($past(string_bytes)))) else $error("Index step wrong");
  dbg_cause_a: assert property (exc_valid && exc_vector == sfc_pkg::EXC_DEBUG |-> $past(instr_done))
    else $error("Debug trap without completion");
  rsv_zero_a: assert property ((flags_out & ~sfc_pkg::FL_MASK) == 32'h0
    && (cw_out & ~sfc_pkg::CW_MASK) == 32'h0) else $error("Reserved bit set");
  cw_view_a: assert property (align_check_on == cw_out[18] && sup_write_protect == cw_out[16])
    else $error("Control views disagree");
endmodule

bind sfc_core sfc_core_asserts #(.W(W)) u_sfc_core_asserts (.core_clk, .rst_b, .flags_wr, .current_priv_level,
  .cw_wr, .cw_image, .instr_done, .io_instr, .string_step, .string_bytes, .flags_out, .cw_out, .exc_valid,
  .exc_vector, .exc_err_code, .io_direct_ok, .irq_take, .index_delta, .align_check_on, .sup_write_protect);

/* verif/sfc_core_bench.sv */
/*
 * Bench for sfc_core: flag table, then privilege, interrupt,
 * control word, I/O, string and trap cases.
 * Assumes: sfc_pkg, design and checker compiled first.
 */
`timescale 1ns/10ps
module sfc_core_bench;
  typedef struct packed {
    sfc_pkg::sfc_alu_e op;
    sfc_pkg::sfc_size_e sz;
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
    logic [11:0] f;
  } sfc_row_s;
  localparam sfc_row_s ROWS [8] = '{
    '{sfc_pkg::OP_ADD, sfc_pkg::SZ_BYTE, 32'hff, 32'h1, 32'h0, 12'h055},
    '{sfc_pkg::OP_ADD, sfc_pkg::SZ_BYTE, 32'h7f, 32'h1, 32'h80, 12'h890},
    '{sfc_pkg::OP_SUB, sfc_pkg::SZ_WORD, 32'h0, 32'h1, 32'hffff, 12'h095},
    '{sfc_pkg::OP_ADD, sfc_pkg::SZ_DWORD, 32'h7fff_ffff, 32'h1, 32'h8000_0000, 12'h894},
    '{sfc_pkg::OP_LOGIC, sfc_pkg::SZ_DWORD, 32'hff00_ff00, 32'h0f0f_0f0f, 32'h0f00_0f00, 12'h004},
    '{sfc_pkg::OP_ADD, sfc_pkg::SZ_WORD, 32'h0100, 32'h3, 32'h0103, 12'h004},
    '{sfc_pkg::OP_ADD, sfc_pkg::SZ_WORD, 32'hffff, 32'h1, 32'h0, 12'h055},
    '{sfc_pkg::OP_SUB, sfc_pkg::SZ_BYTE, 32'h80, 32'h1, 32'h7f, 12'h810}
  };
  logic core_clk, rst_b, alu_valid, instr_done, bp_match, io_instr, string_step, maskable_irq_pin;
  sfc_pkg::sfc_alu_e alu_op;
  sfc_pkg::sfc_size_e alu_size;
  sfc_pkg::sfc_fwr_e flags_wr;
  sfc_pkg::sfc_cwr_e cw_wr;
  logic [31:0] alu_a, alu_b, flags_image, cw_image, flags_out, cw_out, alu_result, index_delta;
  logic [1:0] current_priv_level;
  logic [2:0] string_bytes;
  logic [7:0] exc_vector;
  logic [15:0] exc_err_code;
  logic exc_valid, io_direct_ok, irq_take, align_check_on, sup_write_protect;
  int n_mismatch, num_checks;

  sfc_core u_sfc_core (.core_clk, .rst_b, .alu_valid, .alu_op, .alu_size, .alu_a, .alu_b, .flags_wr,
    .flags_image, .current_priv_level, .cw_wr, .cw_image, .instr_done, .bp_match, .io_instr, .string_step,
    .string_bytes, .maskable_irq_pin, .flags_out, .cw_out, .alu_result, .exc_valid, .exc_vector,
    .exc_err_code, .io_direct_ok, .irq_take, .index_delta, .align_check_on, .sup_write_protect);

  // ****************************************
  // Tasks
  // ****************************************
  // One edge, then drop the one-cycle requests
  task automatic cyc();
    @(posedge core_clk);
    #1;
    alu_valid = 1'b0;
    flags_wr = sfc_pkg::FW_NONE;
    cw_wr = sfc_pkg::CW_NONE;
    instr_done = 1'b0;
    bp_match = 1'b0;
    io_instr = 1'b0;
    string_step = 1'b0;
  endtask
  task automatic fw(input sfc_pkg::sfc_fwr_e k, input logic [31:0] img, input logic [1:0] pl);
    flags_wr = k;
    flags_image = img;
    current_priv_level = pl;
    cyc();
  endtask
  task automatic cw(input sfc_pkg::sfc_cwr_e k, input logic [31:0] img);
    cw_wr = k;
    cw_image = img;
    cyc();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    #2000000;
    n_mismatch++;
    test_done();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {alu_valid, instr_done, bp_match, io_instr, string_step, maskable_irq_pin} = 6'h0;
    {alu_a, alu_b, flags_image, cw_image, current_priv_level, string_bytes} = '0;
    alu_op = sfc_pkg::OP_ADD;
    alu_size = sfc_pkg::SZ_BYTE;
    flags_wr = sfc_pkg::FW_NONE;
    cw_wr = sfc_pkg::CW_NONE;
    rst_b = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) cyc();
    chk("flags", 32'h0, flags_out);
    chk("cw", 32'h4000_0000, cw_out);
    chk("io_ok", 32'h1, {31'h0, io_direct_ok});
    foreach (ROWS[i]) begin
      alu_valid = 1'b1;
      alu_op = ROWS[i].op;
      alu_size = ROWS[i].sz;
      alu_a = ROWS[i].a;
      alu_b = ROWS[i].b;
      cyc();
      chk("result", ROWS[i].r, alu_result);
      chk("arith", {20'h0, ROWS[i].f}, flags_out & 32'h0000_08d5);
    end
    // Privilege filtering of flag images
    fw(sfc_pkg::FW_DIRECT, 32'hffff_ffff, 2'h0);
    chk("flags", 32'h0000_3fd5, flags_out);
    fw(sfc_pkg::FW_DIRECT, 32'h0, 2'h0);
    fw(sfc_pkg::FW_POP_FLAGS_INSTR, 32'h3200, 2'h3);
    chk("pop_flags_instr", 32'h0, flags_out);
    fw(sfc_pkg::FW_TASK, 32'h3200, 2'h3);
    chk("task", 32'h3200, flags_out);
    fw(sfc_pkg::FW_POP_FLAGS_INSTR, 32'h0, 2'h2);
    chk("pop_flags_instr", 32'h3000, flags_out);
    fw(sfc_pkg::FW_INTERRUPT_RETURN_INSTR, 32'h1200, 2'h0);
    chk("interrupt_return_instr", 32'h1200, flags_out);
    // Interrupt gating
    maskable_irq_pin = 1'b1;
    fw(sfc_pkg::FW_DIRECT, 32'h0, 2'h0);
    chk("irq", 32'h1, {31'h0, irq_take});
    cyc();
    chk("irq", 32'h0, {31'h0, irq_take});
    maskable_irq_pin = 1'b0;
    // Control word loads
    cw(sfc_pkg::CW_MOV, 32'h8000_0000);
    chk("exc", 32'h010d_0000, {7'h0, exc_valid, exc_vector, exc_err_code});
    chk("cw", 32'h4000_0000, cw_out);
    cw(sfc_pkg::CW_MOV, 32'h2000_0000);
    chk("exc", 32'h10d, {23'h0, exc_valid, exc_vector});
    chk("cw", 32'h4000_0000, cw_out);
    cw(sfc_pkg::CW_MOV, 32'hffff_ffff);
    chk("cw", 32'he005_002f, cw_out);
    chk("views", 32'h3, {30'h0, align_check_on, sup_write_protect});
    cw(sfc_pkg::CW_LMSW, 32'h0000_0021);
    chk("cw", 32'he005_0021, cw_out);
    cw(sfc_pkg::CW_MOV, 32'h0000_0001);
    chk("views", 32'h0, {30'h0, align_check_on, sup_write_protect});
    // I/O threshold, threshold one
    fw(sfc_pkg::FW_DIRECT, 32'h1000, 2'h1);
    io_instr = 1'b1;
    cyc();
    chk("io_ok", 32'h1, {31'h0, io_direct_ok});
    current_priv_level = 2'h2;
    io_instr = 1'b1;
    cyc();
    chk("io_ok", 32'h0, {31'h0, io_direct_ok});
    // String index step both ways
    string_step = 1'b1;
    string_bytes = 3'h4;
    cyc();
    chk("delta", 32'h4, index_delta);
    fw(sfc_pkg::FW_DIRECT, 32'h0400, 2'h0);
    string_step = 1'b1;
    string_bytes = 3'h2;
    cyc();
    chk("delta", 32'hffff_fffe, index_delta);
    // Single step: arm, then trap
    fw(sfc_pkg::FW_DIRECT, 32'h0100, 2'h0);
    instr_done = 1'b1;
    cyc();
    chk("exc", 32'h0, {31'h0, exc_valid});
    instr_done = 1'b1;
    cyc();
    chk("exc", 32'h101, {23'h0, exc_valid, exc_vector});
    // Breakpoint with step off, after the armed step drains
    fw(sfc_pkg::FW_DIRECT, 32'h0, 2'h0);
    instr_done = 1'b1;
    cyc();
    instr_done = 1'b1;
    cyc();
    chk("exc", 32'h0, {31'h0, exc_valid});
    instr_done = 1'b1;
    bp_match = 1'b1;
    cyc();
    chk("exc", 32'h101, {23'h0, exc_valid, exc_vector});
    test_done();
  end
endmodule
